// ---- shared/scpgw_pkg.sv ----
// constants of the serial control port and the amplifier gain writer
// assumes core clock at 25 MHz and a host serial clock up to 10 MHz
package scpgw_pkg;
    // register map
    localparam logic [4:0] ADDR_SERIAL_PORT_CONFIG = 5'h00;
    localparam logic [4:0] ADDR_AMP_GAIN_ONE = 5'h07;
    localparam logic [4:0] ADDR_AMP_GAIN_TWO = 5'h0d;
    localparam logic [4:0] ADDR_AMP_GAIN_THREE = 5'h13;
    localparam logic [4:0] ADDR_AMP_GAIN_FOUR = 5'h19;
    localparam logic [4:0] ADDR_LAST = 5'h19;
    localparam logic [4:0] ADDR_FIRST = 5'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    // config fields
    localparam int CFG_SPLIT_READ_BIT = 7;
    localparam int CFG_LSB_FIRST_BIT = 6;
    // instruction byte fields
    localparam int INSTR_READ_BIT = 7;
    localparam int INSTR_COUNT_HI = 6;
    localparam int INSTR_COUNT_LO = 5;
    localparam int INSTR_ADDR_HI = 4;
    // amplifier transfer timing in core clock cycles
    localparam int CORE_CLK_MHZ = 25;
    localparam int AMP_XFER_CYCLES = 136;
    localparam int AMP_LEAD_CYCLES = 4;
    localparam int AMP_BIT_CYCLES = 16;
    localparam int AMP_CLK_HIGH_FROM = 8;
    localparam int AMP_FRAME_END = AMP_LEAD_CYCLES + 8 * AMP_BIT_CYCLES;
    localparam logic [7:0] AMP_CNT_LAST = 8'(AMP_XFER_CYCLES - 1);
    typedef enum logic {SCPGW_INSTR, SCPGW_DATA} scpgw_phase_t;
endpackage

// ---- rtl/scpgw_top.sv ----
// serial control port with gain forwarding to an external cable amplifier
// assumes host drives ser_clk_in, select, resync and data in that domain
//
// How it works
// R1 - instruction top bit: one reads, zero writes
// R2 - bits six, five give one to four bytes
// R3 - low five bits start address, then auto-stepped
// R4 - select high floats both data lines
// R5 - select high freezes cycle, resumes when low
// R6 - config bit seven moves read data off shared line
// R7 - shared-line mode keeps read line floated
// R8 - resync high aborts cycle, keeps registers intact
// R9 - config bit six picks lsb-first order
// R10 - msb-first decrements address, lsb-first increments
// R11 - config writes act immediately, mid-cycle too
// R12 - address wraps between 0h and 19h
// R13 - exact byte count, then new instruction
// R14 - host serial clock at most 10 MHz
// R15 - amplifier transfer lasts 136 core cycles
// R16 - power-up clears gains, sends zero gain
// R17 - profile pin change sends selected gain
// R18 - any gain register write sends current gain
// R19 - gain write aborts running transfer, restarts
// R20 - sample on rising, drive on falling edge
// R21 - profile pins 00..11 pick profiles one..four
// R22 - frame high, eight clocked bits, frame drops
`timescale 1ns/1ns
module scpgw_top (
    // core clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // serial control port
    input wire logic ser_clk_in,
    input wire logic ser_sel_n_in,
    input wire logic ser_resync_in,
    input wire logic ser_data_in,
    output logic ser_data_out,
    output logic ser_data_oe_out,
    output logic read_data_line_out,
    output logic read_data_line_oe_out,
    // profile selection
    input wire logic [1:0] profile_select_pins_in,
    // amplifier control lines
    output logic amp_ctrl_clock_out,
    output logic amp_ctrl_data_out,
    output logic amp_ctrl_frame_out
);
    import scpgw_pkg::*;

    function automatic logic is_gain_addr(input logic [4:0] a);
        is_gain_addr = (a == ADDR_AMP_GAIN_ONE) || (a == ADDR_AMP_GAIN_TWO) ||
            (a == ADDR_AMP_GAIN_THREE) || (a == ADDR_AMP_GAIN_FOUR);
    endfunction

    // ---------------- serial clock domain ----------------
    logic ser_clr_n;
    scpgw_phase_t phase_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic read_q;
    logic [1:0] left_q;
    logic [4:0] addr_q;
    logic [7:0] config_q;
    logic [7:0] gain_q [4];
    logic gain_tog_q;
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    logic lsb_first;
    logic byte_done;
    logic [4:0] addr_next;

    // resync clears the bit collection, sequencer and read-out flops, never the register contents
    assign ser_clr_n = rst_n_in & ~ser_resync_in; // R8
    assign lsb_first = config_q[CFG_LSB_FIRST_BIT]; // R9 R11
    assign byte_done = (bit_cnt_q == 3'h7) && !ser_sel_n_in;
    always_comb begin
        if (lsb_first) begin // R9
            byte_in = {ser_data_in, shift_q};
        end else begin
            byte_in = {shift_q, ser_data_in};
        end
    end

    always_comb begin
        if (lsb_first) begin // R10
            addr_next = (addr_q == ADDR_LAST) ? ADDR_FIRST : addr_q + 5'h01; // R12
        end else begin
            addr_next = (addr_q == ADDR_FIRST) ? ADDR_LAST : addr_q - 5'h01; // R12
        end
    end

    always_comb begin
        case (addr_q)
            ADDR_SERIAL_PORT_CONFIG: rd_byte = config_q;
            ADDR_AMP_GAIN_ONE: rd_byte = gain_q[0];
            ADDR_AMP_GAIN_TWO: rd_byte = gain_q[1];
            ADDR_AMP_GAIN_THREE: rd_byte = gain_q[2];
            ADDR_AMP_GAIN_FOUR: rd_byte = gain_q[3];
            default: rd_byte = 8'h00;
        endcase
    end

    // bit collection; select high holds everything in place
    always_ff @(posedge ser_clk_in or negedge ser_clr_n) begin // R20
        if (!ser_clr_n) begin
            bit_cnt_q <= 3'h0;
            shift_q <= 7'h00;
        end else if (!ser_sel_n_in) begin // R5
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (lsb_first) begin
                shift_q <= {ser_data_in, shift_q[6:1]};
            end else begin
                shift_q <= {shift_q[5:0], ser_data_in};
            end
        end
    end

    // cycle sequencer
    always_ff @(posedge ser_clk_in or negedge ser_clr_n) begin
        if (!ser_clr_n) begin
            phase_q <= SCPGW_INSTR;
            read_q <= 1'b0;
            left_q <= 2'h0;
            addr_q <= 5'h00;
        end else if (byte_done) begin
            case (phase_q)
                SCPGW_INSTR: begin
                    phase_q <= SCPGW_DATA;
                    read_q <= byte_in[INSTR_READ_BIT]; // R1
                    left_q <= byte_in[INSTR_COUNT_HI:INSTR_COUNT_LO]; // R2
                    addr_q <= byte_in[INSTR_ADDR_HI:0]; // R3
                end
                SCPGW_DATA: begin
                    addr_q <= addr_next; // R3
                    left_q <= left_q - 2'h1;
                    if (left_q == 2'h0) begin
                        phase_q <= SCPGW_INSTR; // R13
                    end
                end
                default: phase_q <= SCPGW_INSTR;
            endcase
        end
    end

    // register writes; takes effect on the very next bit
    always_ff @(posedge ser_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_q <= CONFIG_RESET;
            gain_q <= '{default: GAIN_RESET}; // R16
            gain_tog_q <= 1'b0;
        end else if (byte_done && phase_q == SCPGW_DATA && !read_q) begin
            case (addr_q)
                ADDR_SERIAL_PORT_CONFIG: config_q <= byte_in; // R11
                ADDR_AMP_GAIN_ONE: gain_q[0] <= byte_in;
                ADDR_AMP_GAIN_TWO: gain_q[1] <= byte_in;
                ADDR_AMP_GAIN_THREE: gain_q[2] <= byte_in;
                ADDR_AMP_GAIN_FOUR: gain_q[3] <= byte_in;
                default: config_q <= config_q;
            endcase
            if (is_gain_addr(addr_q)) begin
                gain_tog_q <= ~gain_tog_q; // R18
            end
        end
    end

    // read data goes out on the falling edge
    logic rd_bit_q;
    logic rd_en_q;
    logic [2:0] rd_idx;
    assign rd_idx = lsb_first ? bit_cnt_q : 3'h7 - bit_cnt_q;
    always_ff @(negedge ser_clk_in or negedge ser_clr_n) begin // R20
        if (!ser_clr_n) begin
            rd_bit_q <= 1'b0;
            rd_en_q <= 1'b0;
        end else if (!ser_sel_n_in) begin // R5
            rd_bit_q <= rd_byte[rd_idx];
            rd_en_q <= (phase_q == SCPGW_DATA) && read_q; // R1
        end
    end

    logic drive;
    assign drive = rd_en_q && !ser_sel_n_in; // R4
    assign ser_data_out = rd_bit_q;
    assign read_data_line_out = rd_bit_q;
    assign ser_data_oe_out = drive && !config_q[CFG_SPLIT_READ_BIT]; // R6
    assign read_data_line_oe_out = drive && config_q[CFG_SPLIT_READ_BIT]; // R7

    // ---------------- core clock domain ----------------
    logic [1:0] prof_s1_q;
    logic [1:0] prof_s2_q;
    logic [1:0] prof_prev_q;
    logic [3:0] tog_sync_q;
    logic gain_copy;
    logic [7:0] gain_core_q [4];
    logic pwr_pend_q;
    logic prof_chg;
    logic gain_evt;
    logic start;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prof_s1_q <= 2'h0;
            prof_s2_q <= 2'h0;
            prof_prev_q <= 2'h0;
            tog_sync_q <= 4'h0;
        end else begin
            prof_s1_q <= profile_select_pins_in;
            prof_s2_q <= prof_s1_q;
            prof_prev_q <= prof_s2_q;
            tog_sync_q <= {tog_sync_q[2:0], gain_tog_q};
        end
    end

    assign prof_chg = prof_s2_q != prof_prev_q; // R17
    // copy one cycle ahead of the start so the shifter loads fresh bytes;
    // only the second stage and later are read, never the first
    assign gain_copy = tog_sync_q[2] != tog_sync_q[1];
    assign gain_evt = tog_sync_q[3] != tog_sync_q[2]; // R18

    // gain bytes stay still for a whole serial byte, far longer than the
    // toggle takes to cross, so the copy lands on settled values
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gain_core_q <= '{default: GAIN_RESET}; // R16
        end else if (gain_copy) begin
            gain_core_q <= gain_q;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_pend_q <= 1'b1; // R16
        end else begin
            pwr_pend_q <= 1'b0;
        end
    end

    assign start = pwr_pend_q || prof_chg || gain_evt; // R16 R17 R18

    // amplifier shifter
    logic busy_q;
    logic [7:0] cnt_q;
    logic [7:0] amp_byte_q;
    logic [3:0] bit_slot;
    logic [2:0] bit_num;
    logic [7:0] in_bits;
    assign in_bits = cnt_q - 8'(AMP_LEAD_CYCLES);
    assign bit_slot = in_bits[3:0];
    assign bit_num = 3'h7 - in_bits[6:4];

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            amp_byte_q <= 8'h00;
        end else if (start) begin
            // restart drops the running frame without a latch
            busy_q <= 1'b1; // R19
            cnt_q <= 8'h00;
            amp_byte_q <= gain_core_q[prof_s2_q]; // R21
        end else if (busy_q) begin
            if (cnt_q == AMP_CNT_LAST) begin // R15
                busy_q <= 1'b0;
                cnt_q <= 8'h00;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

    logic in_shift;
    assign in_shift = busy_q && cnt_q >= 8'(AMP_LEAD_CYCLES) &&
        cnt_q < 8'(AMP_FRAME_END);
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            amp_ctrl_frame_out <= 1'b0;
            amp_ctrl_clock_out <= 1'b0;
            amp_ctrl_data_out <= 1'b0;
        end else begin
            amp_ctrl_frame_out <= busy_q && cnt_q < 8'(AMP_FRAME_END); // R22
            amp_ctrl_clock_out <= in_shift &&
                bit_slot >= 4'(AMP_CLK_HIGH_FROM); // R22
            amp_ctrl_data_out <= in_shift ? amp_byte_q[bit_num] : 1'b0;
        end
    end

    // ---------------- checks ----------------
    a_xfer_length: assert property ( // R15
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        busy_q && cnt_q == AMP_CNT_LAST && !start |=> !busy_q)
        else $error("amplifier transfer length wrong");
    a_start_restart: assert property ( // R19
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        start |=> busy_q && cnt_q == 8'h00)
        else $error("start did not restart transfer");
    a_frame_latch: assert property ( // R22
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        busy_q && cnt_q == 8'(AMP_FRAME_END) && !start |=> !amp_ctrl_frame_out)
        else $error("frame not released for latch");
    a_powerup_send: assert property ( // R16
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        pwr_pend_q |=> busy_q && amp_byte_q == $past(gain_core_q[prof_s2_q]))
        else $error("power-up gain not sent");
    a_profile_byte: assert property ( // R17
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        prof_chg |=> busy_q && amp_byte_q == $past(gain_core_q[prof_s2_q]))
        else $error("profile change sent wrong byte");
    a_gain_write_send: assert property ( // R18
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        gain_evt |=> busy_q && cnt_q == 8'h00)
        else $error("gain write did not start transfer");
    a_sel_float: assert property ( // R4
        @(posedge ser_clk_in) disable iff (!ser_clr_n)
        ser_sel_n_in |-> !ser_data_oe_out && !read_data_line_oe_out)
        else $error("data line driven while deselected");
    a_one_wire_only: assert property ( // R7
        @(negedge ser_clk_in) disable iff (!ser_clr_n)
        !config_q[CFG_SPLIT_READ_BIT] |-> !read_data_line_oe_out)
        else $error("read line driven in shared mode");
    a_instr_count: assert property ( // R13
        @(posedge ser_clk_in) disable iff (!ser_clr_n)
        phase_q == SCPGW_DATA && byte_done && left_q == 2'h0
        |=> phase_q == SCPGW_INSTR && bit_cnt_q == 3'h0)
        else $error("byte count not honoured");
    a_addr_wrap: assert property ( // R12
        @(posedge ser_clk_in) disable iff (!ser_clr_n)
        phase_q == SCPGW_DATA && byte_done && !lsb_first && addr_q == 5'h00
        |=> addr_q == ADDR_LAST)
        else $error("address did not wrap to last");
    a_freeze_sel: assert property ( // R5
        @(posedge ser_clk_in) disable iff (!ser_clr_n)
        ser_sel_n_in |=> $stable(bit_cnt_q) && $stable(phase_q))
        else $error("cycle advanced while deselected");
    a_lsb_wrap: assert property ( // R12
        @(posedge ser_clk_in) disable iff (!ser_clr_n)
        phase_q == SCPGW_DATA && byte_done && lsb_first && addr_q == ADDR_LAST
        |=> addr_q == ADDR_FIRST)
        else $error("address did not wrap to first");
    a_frame_idle: assert property ( // R22
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !busy_q |=> !amp_ctrl_frame_out)
        else $error("frame raised while idle");
endmodule

// ---- sim/scpgw_amp_model.sv ----
// behavioural model of the external gain amplifier's serial input
// assumes frame high brackets the bits, clock rising takes each bit
`timescale 1ns/1ns
module scpgw_amp_model (
    // amplifier control lines from the device
    input wire logic amp_ctrl_clock_in,
    input wire logic amp_ctrl_data_in,
    input wire logic amp_ctrl_frame_in,
    // gain the amplifier holds
    output logic [7:0] gain_out,
    output int latch_count_out
);
    logic [7:0] shift_q = 8'h00;

    initial begin
        gain_out = 8'h00;
        latch_count_out = 0;
    end

    always @(posedge amp_ctrl_clock_in) begin
        if (amp_ctrl_frame_in) begin
            shift_q <= {shift_q[6:0], amp_ctrl_data_in};
        end
    end

    // like the real part, an aborted frame leaves the last eight bits
    always @(negedge amp_ctrl_frame_in) begin
        gain_out <= shift_q;
        latch_count_out <= latch_count_out + 1;
    end
endmodule

// ---- sim/scpgw_bench.sv ----
// self-checking bench: host serial port driven here, amplifier modelled
// assumes serial clock runs inside frames and during select pauses, period 15 ns
`timescale 1ns/1ns
module scpgw_bench;
    import scpgw_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b1;
    logic ser_clk_in = 1'b0;
    logic ser_sel_n_in = 1'b1;
    logic ser_resync_in = 1'b0;
    logic ser_data_in = 1'b0;
    logic [1:0] profile_select_pins_in = 2'h0;
    logic ser_data_out, ser_data_oe_out;
    logic read_data_line_out, read_data_line_oe_out;
    logic amp_ctrl_clock_out, amp_ctrl_data_out, amp_ctrl_frame_out;
    logic [7:0] amp_gain;
    int latch_count;
    int checked = 0;
    int miscompares = 0;
    logic [1:0] oe_now, oe_exp;
    logic oe_ok;

    scpgw_top u_scpgw_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .ser_clk_in(ser_clk_in), .ser_sel_n_in(ser_sel_n_in),
        .ser_resync_in(ser_resync_in), .ser_data_in(ser_data_in),
        .ser_data_out(ser_data_out), .ser_data_oe_out(ser_data_oe_out),
        .read_data_line_out(read_data_line_out),
        .read_data_line_oe_out(read_data_line_oe_out),
        .profile_select_pins_in(profile_select_pins_in),
        .amp_ctrl_clock_out(amp_ctrl_clock_out),
        .amp_ctrl_data_out(amp_ctrl_data_out),
        .amp_ctrl_frame_out(amp_ctrl_frame_out));

    scpgw_amp_model u_scpgw_amp_model (.amp_ctrl_clock_in(amp_ctrl_clock_out),
        .amp_ctrl_data_in(amp_ctrl_data_out),
        .amp_ctrl_frame_in(amp_ctrl_frame_out),
        .gain_out(amp_gain), .latch_count_out(latch_count));

    initial begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    task automatic final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    // data set while clock low, read bit taken just before the rise;
    // the 15 ns period overdrives the host limit as a stress case;
    // trailing 1 ns keeps callers' select changes off the falling edge
    task automatic sbit(input logic b, output logic r);
        ser_data_in = b;
        #7;
        r = oe_exp[0] ? read_data_line_out : ser_data_out;
        oe_now = {ser_data_oe_out, read_data_line_oe_out};
        ser_clk_in = 1'b1;
        #7;
        ser_clk_in = 1'b0;
        #1;
    endtask

    // fz: bit index where select pauses; rs: bit index where resync aborts
    task automatic cyc(input logic [7:0] ins, input logic [31:0] d,
                       input int n, input logic lsb, input int fz,
                       input int rs, output logic [31:0] q);
        logic [39:0] all;
        logic r;
        int k;
        all = {d, ins};
        q = '0;
        oe_ok = 1'b1;
        ser_sel_n_in = 1'b0;
        for (int i = 0; i < 8 * (n + 1); i++) begin
            k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
            if (i == rs) begin
                ser_resync_in = 1'b1;
                #20;
                ser_resync_in = 1'b0;
                break;
            end
            if (i == fz) begin
                ser_sel_n_in = 1'b1;
                #1;
                check1(ser_data_oe_out | read_data_line_oe_out, 1'b0);
                repeat (3) sbit(~all[k], r);
                ser_sel_n_in = 1'b0;
            end
            sbit(all[k], r);
            if (i >= 8) begin
                q[k - 8] = r;
                oe_ok &= (oe_now === oe_exp);
            end
        end
        ser_sel_n_in = 1'b1;
        #15;
    endtask

    task automatic wait_frame(input logic lvl, output int t);
        t = 0;
        while (amp_ctrl_frame_out !== lvl) begin
            @(posedge ref_clk_in);
            #1;
            t++;
            if (t > 400) begin
                miscompares++;
                $display("unexpected at %0t: frame stuck", $time);
                final_report();
            end
        end
    endtask

    task automatic wait_latch(input int n0, input logic [7:0] exp);
        int t;
        t = 0;
        while (latch_count == n0) begin
            @(posedge ref_clk_in);
            #1;
            t++;
            if (t > 600) begin
                miscompares++;
                $display("unexpected at %0t: no gain update", $time);
                final_report();
            end
        end
        check8(amp_gain, exp);
    endtask

    task automatic set_profile(input logic [1:0] p, input logic [7:0] exp);
        int n0;
        n0 = latch_count;
        @(posedge ref_clk_in);
        profile_select_pins_in <= p;
        wait_latch(n0, exp);
    endtask

    initial begin
        logic [31:0] q;
        int n0;
        int t;
        // a real falling edge, so every asynchronous reset fires
        rst_n_in <= 1'b0;
        oe_exp = 2'b10;
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        wait_frame(1'b1, t);
        wait_frame(1'b0, t);
        check8(8'(t), 8'h84);
        check8(amp_gain, GAIN_RESET);
        n0 = latch_count;
        cyc(8'h07, 32'h5a, 1, 1'b0, -1, -1, q);
        wait_latch(n0, 8'h5a);
        cyc(8'h87, 32'h0, 1, 1'b0, -1, -1, q);
        check8(q[7:0], 8'h5a);
        check1(oe_ok, 1'b1);
        cyc(8'h87, 32'h0, 1, 1'b0, 11, -1, q);
        check8(q[7:0], 8'h5a);
        check1(oe_ok, 1'b1);
        n0 = latch_count;
        cyc(8'h20, 32'hc300, 2, 1'b0, -1, -1, q);
        wait_latch(n0, 8'h5a);
        set_profile(2'h3, 8'hc3);
        set_profile(2'h0, 8'h5a);
        n0 = latch_count;
        cyc(8'h07, 32'h3c, 1, 1'b0, 12, -1, q);
        wait_latch(n0, 8'h3c);
        cyc(8'h07, 32'hff, 1, 1'b0, -1, 4, q);
        n0 = latch_count;
        cyc(8'h07, 32'h81, 1, 1'b0, -1, -1, q);
        wait_latch(n0, 8'h81);
        n0 = latch_count;
        cyc(8'h07, 32'h11, 1, 1'b0, -1, -1, q);
        cyc(8'h07, 32'h22, 1, 1'b0, -1, -1, q);
        wait_latch(n0, 8'h22);
        cyc(8'h00, 32'h40, 1, 1'b0, -1, -1, q);
        n0 = latch_count;
        cyc(8'h07, 32'h96, 1, 1'b1, -1, -1, q);
        wait_latch(n0, 8'h96);
        cyc(8'h39, 32'h0077, 2, 1'b1, -1, -1, q);
        set_profile(2'h3, 8'h77);
        cyc(8'h99, 32'h0, 1, 1'b0, -1, -1, q);
        check8(q[7:0], 8'h77);
        cyc(8'h00, 32'h80, 1, 1'b0, -1, -1, q);
        oe_exp = 2'b01;
        cyc(8'h87, 32'h0, 1, 1'b0, -1, -1, q);
        check8(q[7:0], 8'h96);
        check1(oe_ok, 1'b1);
        final_report();
    end
endmodule
